// ==== hw/card_supply_class_sequencer.v ====
`timescale 1ns/1ns
`default_nettype none
`include "supply_seq_defs.vh"
module card_supply_class_sequencer #(
  parameter [15:0] ATR_TIMEOUT = `ATR_TIMEOUT_CLKS,
  parameter [15:0] RST_LOW = `RST_LOW_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire irq_o,
  output reg [2:0] vcc_sel_o,
  output reg card_rst_o,
  output wire card_clk_o,
  input wire card_io_i,
  input wire atr_done_i,
  input wire atr_bad_i,
  input wire atr_class_valid_i,
  input wire [5:0] atr_class_i,
  output reg card_active_o,
  output reg select_done_o
);
  // ========================================================================
  // States.
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_POWER = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_ANSWER = 3'h3;
  localparam [2:0] S_OFF = 3'h4;
  localparam [2:0] S_ACCEPT = 3'h5;
  localparam [2:0] S_REJECT = 3'h6;

  reg [31:0] ctrl_r;
  reg [4:0] event_r;
  reg [4:0] mask_r;
  reg [2:0] state_r;
  reg [2:0] class_r;
  reg [2:0] next_class_r;
  reg [1:0] corrupt_r;
  reg first_r;
  reg [15:0] cnt_r;
  reg [4:0] ev_set;
  reg [2:0] state_nxt;
  reg [2:0] class_nxt;
  reg [2:0] next_class_nxt;
  reg [1:0] corrupt_nxt;
  reg first_nxt;
  reg [15:0] cnt_nxt;

  wire io_q;
  wire io_fall;
  wire clk_rise;
  wire clk_run = (state_r == S_POWER) || (state_r == S_WAIT) || (state_r == S_ANSWER) ||
                 (state_r == S_ACCEPT);
  wire [2:0] term_classes = ctrl_r[`CTRL_TERM_CLASSES];
  wire [7:0] div_raw = ctrl_r[`CTRL_DIV];
  wire [7:0] div_half = (div_raw < `CLK_DIV_MIN) ? `CLK_DIV_MIN :
                        (div_raw > `CLK_DIV_MAX) ? `CLK_DIV_MAX : div_raw;

  // ========================================================================
  // Class helpers: highest set bit (lowest voltage class), and next class above the current one.
  function [2:0] lowest;
    input [2:0] m;
    begin
      if (m[`CLASS_C]) begin
        lowest = 3'h4;
      end else if (m[`CLASS_B]) begin
        lowest = 3'h2;
      end else if (m[`CLASS_A]) begin
        lowest = 3'h1;
      end else begin
        lowest = 3'h0;
      end
    end
  endfunction

  // Higher voltage means lower bit index: C (1.8 V) -> B (3 V) -> A (5 V).
  function [2:0] step_up;
    input [2:0] c;
    input [2:0] m;
    begin
      step_up = (c >> 1) & m;
    end
  endfunction

  function contiguous;
    input [2:0] m;
    begin
      contiguous = (m != 3'h5) && (m != 3'h0);
    end
  endfunction

  card_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(clk_run),
    .half_i(div_half),
    .card_clk_o(card_clk_o),
    .rise_o(clk_rise)
  );

  io_sync u_io (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(card_io_i),
    .q_o(io_q),
    .fall_o(io_fall)
  );

  // ========================================================================
  // Sequencer.
  wire [2:0] card_set = atr_class_i[2:0];
  wire [2:0] common = card_set & term_classes;
  always @* begin
    state_nxt = state_r;
    class_nxt = class_r;
    next_class_nxt = next_class_r;
    corrupt_nxt = corrupt_r;
    first_nxt = first_r;
    cnt_nxt = cnt_r;
    ev_set = 5'h00;
    case (state_r)
      S_IDLE: begin
        if (ctrl_r[`CTRL_START] && term_classes != 3'h0) begin
          class_nxt = lowest(term_classes);
          corrupt_nxt = 2'h0;
          first_nxt = 1'b1;
          cnt_nxt = 16'h0000;
          state_nxt = S_POWER;
        end
      end
      S_POWER: begin
        // Reset held low for a fixed count of card clocks.
        if (clk_rise) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= RST_LOW) begin
            cnt_nxt = 16'h0000;
            state_nxt = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (io_fall) begin
          state_nxt = S_ANSWER;
        end else if (clk_rise) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= ATR_TIMEOUT) begin
            ev_set[`EV_NO_ATR] = 1'b1;
            next_class_nxt = step_up(class_r, term_classes);
            state_nxt = S_OFF;
          end
        end
      end
      S_ANSWER: begin
        if (atr_done_i) begin
          if (atr_bad_i) begin
            ev_set[`EV_CORRUPT] = 1'b1;
            corrupt_nxt = corrupt_r + 2'h1;
            next_class_nxt = class_r;
            if (corrupt_r + 2'h1 >= `CORRUPT_LIMIT) begin
              corrupt_nxt = 2'h0;
              next_class_nxt = ctrl_r[`CTRL_RETRY_UP] ?
                               step_up(class_r, term_classes) : 3'h0;
            end
            state_nxt = S_OFF;
          end else if (first_r && atr_class_valid_i && ((card_set & class_r) == 3'h0)) begin
            if (contiguous(card_set) && common != 3'h0) begin
              ev_set[`EV_RESELECT] = 1'b1;
              next_class_nxt = lowest(common);
            end else begin
              next_class_nxt = 3'h0;
            end
            state_nxt = S_OFF;
          end else begin
            ev_set[`EV_ACCEPT] = 1'b1;
            state_nxt = S_ACCEPT;
          end
        end
      end
      S_OFF: begin
        first_nxt = 1'b0;
        cnt_nxt = 16'h0000;
        if (next_class_r == 3'h0) begin
          ev_set[`EV_REJECT] = 1'b1;
          state_nxt = S_REJECT;
        end else begin
          class_nxt = next_class_r;
          state_nxt = S_POWER;
        end
      end
      S_ACCEPT, S_REJECT: begin
        if (!ctrl_r[`CTRL_START]) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      class_r <= 3'h0;
      next_class_r <= 3'h0;
      corrupt_r <= 2'h0;
      first_r <= 1'b0;
      cnt_r <= 16'h0000;
      vcc_sel_o <= 3'h0;
      card_rst_o <= 1'b0;
      card_active_o <= 1'b0;
      select_done_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      class_r <= class_nxt;
      next_class_r <= next_class_nxt;
      corrupt_r <= corrupt_nxt;
      first_r <= first_nxt;
      cnt_r <= cnt_nxt;
      vcc_sel_o <= (state_nxt == S_POWER || state_nxt == S_WAIT ||
                    state_nxt == S_ANSWER || state_nxt == S_ACCEPT) ? class_nxt : 3'h0;
      card_rst_o <= (state_nxt == S_WAIT) || (state_nxt == S_ANSWER) ||
                    (state_nxt == S_ACCEPT);
      card_active_o <= (state_nxt == S_ACCEPT);
      // Nothing else may start on the card until selection is over.
      select_done_o <= (state_nxt == S_ACCEPT) || (state_nxt == S_REJECT);
    end
  end

  // ========================================================================
  // Wishbone slave, one wait state; all reads answered, unmapped read as zero.
  wire req = cyc_i && stb_i && !ack_o;
  wire rd_event = req && !we_i && (adr_i == `REG_EVENT);
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      ctrl_r <= `CTRL_RESET;
      mask_r <= 5'h00;
      event_r <= 5'h00;
    end else begin
      ack_o <= req;
      // A new event wins over the read that clears it.
      event_r <= (rd_event ? 5'h00 : event_r) | ev_set;
      if (req && we_i) begin
        if (adr_i == `REG_CTRL) begin
          if (sel_i[0]) ctrl_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) ctrl_r[15:8] <= dat_i[15:8];
        end
        if (adr_i == `REG_MASK && sel_i[0]) begin
          mask_r <= dat_i[4:0];
        end
      end
      if (req && !we_i) begin
        case (adr_i)
          `REG_CTRL: dat_o <= {16'h0000, ctrl_r[15:0]};
          `REG_STATUS: dat_o <= {16'h0000, io_q, 2'h0, corrupt_r, first_r, 1'b0,
                                 card_active_o, 2'h0, class_r, state_r};
          `REG_EVENT: dat_o <= {27'h0000000, event_r};
          `REG_MASK: dat_o <= {27'h0000000, mask_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign irq_o = |(event_r & mask_r);
endmodule // card_supply_class_sequencer
`default_nettype wire

// ==== hw/supply_seq_defs.vh ====
`ifndef SUPPLY_SEQ_DEFS_VH
`define SUPPLY_SEQ_DEFS_VH
// ==========================================================================
// Register offsets (byte addresses, one word each).
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_EVENT 4'h8
`define REG_MASK 4'hC
// ==========================================================================
// Control register fields.
`define CTRL_START 0
`define CTRL_RETRY_UP 1
`define CTRL_TERM_CLASSES 4:2
`define CTRL_DIV 15:8
// ==========================================================================
// Class bit positions in the class field.
`define CLASS_A 0
`define CLASS_B 1
`define CLASS_C 2
// ==========================================================================
// Event bits.
`define EV_ACCEPT 0
`define EV_REJECT 1
`define EV_NO_ATR 2
`define EV_CORRUPT 3
`define EV_RESELECT 4
// ==========================================================================
// Reset values and timing.
`define CTRL_RESET 32'h0000_0A1C
`define CORRUPT_LIMIT 2'h3
`define RST_LOW_CYCLES 16'h0190
`define ATR_TIMEOUT_CLKS 16'h9C40
`define CLK_DIV_MIN 8'h05
`define CLK_DIV_MAX 8'h19
`endif

// ==== hw/card_clk_div.v ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Card clock divider with an even half period, so the duty cycle is 50 %.
module card_clk_div (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [7:0] half_i,
  output wire card_clk_o,
  output wire rise_o
);
  reg [7:0] cnt_r;
  reg clk_r;
  wire wrap = (cnt_r + 8'h01 >= half_i);
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r <= 8'h00;
      clk_r <= 1'b0;
    end else if (wrap) begin
      cnt_r <= 8'h00;
      clk_r <= ~clk_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // Gated by run so the clock stops low in the cycle the supply drops.
  assign card_clk_o = clk_r && run_i;
  assign rise_o = run_i && wrap && !clk_r;
endmodule // card_clk_div
`default_nettype wire

// ==== hw/io_sync.v ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Three-stage synchroniser; the level changes when stages two and three agree.
module io_sync (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o,
  output wire fall_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg q_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q_r <= 1'b1;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
  assign q_o = q_r;
  assign fall_o = q_r && (s2_r == s3_r) && !s3_r;
endmodule // io_sync
`default_nettype wire

// ==== testbench/seq_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ======
// Port checks for the class sequencer.
module seq_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [2:0] vcc_sel_o,
  input wire logic card_rst_o,
  input wire logic card_clk_o,
  input wire logic card_active_o,
  input wire logic select_done_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  one_class_a: assert property ($onehot0(vcc_sel_o)) else $error("two classes");
  unpowered_pins_a: assert property (vcc_sel_o == 3'h0 |-> !card_rst_o && !card_clk_o)
    else $error("pins live unpowered");
  class_switch_a: assert property (vcc_sel_o != 3'h0 && $past(vcc_sel_o) != 3'h0
    |-> $stable(vcc_sel_o)) else $error("class change without power off");
  done_on_accept_a: assert property (card_active_o |-> select_done_o)
    else $error("active without done");
  accept_power_a: assert property (card_active_o |-> card_rst_o && vcc_sel_o != 3'h0)
    else $error("accepted card unpowered");
  clk_high_a: assert property ($rose(card_clk_o) |-> (card_clk_o || vcc_sel_o == 3'h0) [*5])
    else $error("short clock high");
endmodule // seq_checker
bind card_supply_class_sequencer seq_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .vcc_sel_o(vcc_sel_o),
  .card_rst_o(card_rst_o), .card_clk_o(card_clk_o), .card_active_o(card_active_o),
  .select_done_o(select_done_o));
`default_nettype wire

// ==== testbench/card_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ======
// Card stand-in: answers only at classes in answer_i, counting card clocks only.
module card_model (
  input wire logic clk_i,
  input wire logic [2:0] vcc_i,
  input wire logic rst_n_i,
  input wire logic cclk_i,
  input wire logic [2:0] answer_i,
  input wire logic [2:0] bad_i,
  input wire logic [2:0] classes_i,
  output logic io_o = 1'b1,
  output logic done_o = 1'b0,
  output logic bad_o,
  output logic [5:0] cls_o
);
  logic cclk_d = 1'b0;
  int n = 0;
  assign bad_o = |(vcc_i & bad_i);
  // Reserved bits stay zero; a gapped set is only sent when a row asks for it.
  assign cls_o = {3'h0, classes_i};
  always @(posedge clk_i) begin
    cclk_d <= cclk_i;
    done_o <= 1'b0;
    if (!rst_n_i || (vcc_i & answer_i) == 3'h0) begin
      n <= 0;
      io_o <= 1'b1;
    end else if (cclk_i && !cclk_d) begin
      n <= n + 1;
      io_o <= !(n >= 8 && n < 12);
      done_o <= (n == 16);
    end
  end
endmodule // card_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "supply_seq_defs.vh"
// ======
// Table rows first, then read-clear, unmapped and mid-run reset cases.
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, irq_o, card_rst_o, card_clk_o, card_io_i, atr_done_i, atr_bad_i;
  logic card_active_o, select_done_o;
  logic [2:0] vcc_sel_o;
  logic [5:0] atr_class_i;
  logic [2:0] ans = 3'h0;
  logic [2:0] bad = 3'h0;
  logic [2:0] cls = 3'h0;
  logic [21:0] rows [8];
  logic [21:0] r;
  int error_cnt = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  // Short timeout and reset-low counts keep every row to a few thousand cycles.
  card_supply_class_sequencer #(.ATR_TIMEOUT(16'h0032), .RST_LOW(16'h0004)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .vcc_sel_o(vcc_sel_o), .card_rst_o(card_rst_o), .card_clk_o(card_clk_o),
    .card_io_i(card_io_i), .atr_done_i(atr_done_i), .atr_bad_i(atr_bad_i),
    .atr_class_valid_i(1'b1), .atr_class_i(atr_class_i), .card_active_o(card_active_o),
    .select_done_o(select_done_o));
  card_model card (.clk_i(clk_i), .vcc_i(vcc_sel_o), .rst_n_i(card_rst_o),
    .cclk_i(card_clk_o), .answer_i(ans), .bad_i(bad), .classes_i(cls), .io_o(card_io_i),
    .done_o(atr_done_i), .bad_o(atr_bad_i), .cls_o(atr_class_i));
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
  initial begin
    // Terminal, step-up, answering, corrupt, card classes; then class, active, events.
    rows[0] = {3'h7, 1'h0, 3'h4, 3'h0, 3'h4, 3'h4, 1'h1, 5'h01};
    rows[1] = {3'h7, 1'h0, 3'h2, 3'h0, 3'h2, 3'h2, 1'h1, 5'h05};
    rows[2] = {3'h3, 1'h0, 3'h3, 3'h0, 3'h1, 3'h1, 1'h1, 5'h11};
    rows[3] = {3'h7, 1'h0, 3'h7, 3'h7, 3'h7, 3'h0, 1'h0, 5'h0A};
    rows[4] = {3'h7, 1'h1, 3'h7, 3'h4, 3'h2, 3'h2, 1'h1, 5'h09};
    rows[5] = {3'h7, 1'h0, 3'h0, 3'h0, 3'h0, 3'h0, 1'h0, 5'h06};
    rows[6] = {3'h3, 1'h0, 3'h7, 3'h0, 3'h5, 3'h0, 1'h0, 5'h02};
    rows[7] = {3'h2, 1'h0, 3'h0, 3'h0, 3'h0, 3'h0, 1'h0, 5'h06};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      ans <= r[17:15];
      bad <= r[14:12];
      cls <= r[11:9];
      wb(1'b1, `REG_MASK, i[0] ? 32'h0 : 32'h1F);
      wb(1'b1, `REG_CTRL, {16'h0, 8'h0A, 3'h0, r[21:18], 1'b1});
      while (select_done_o !== 1'b1) @(posedge clk_i);
      chk(vcc_sel_o, r[8:6]);
      chk(card_active_o, r[5]);
      chk(irq_o, !i[0]);
      wb(1'b0, `REG_EVENT, 32'h0);
      chk(rd, r[4:0]);
      chk(irq_o, 1'b0);
      wb(1'b1, `REG_CTRL, `CTRL_RESET);
    end
    wb(1'b0, `REG_EVENT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    ans <= 3'h7;
    wb(1'b1, `REG_CTRL, 32'h0A1D);
    repeat (30) @(posedge clk_i);
    chk(vcc_sel_o, 32'h4);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({vcc_sel_o, card_rst_o, card_clk_o}, 32'h0);
    wb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    final_report();
  end
endmodule // tb
`default_nettype wire
